// ===== core/prc_defines.svh
// Purpose: Offsets, bit positions and reset values of the reference input config bank
// Assumes: Byte-wide registers on the serial control port, byte addresses
// Notes: Definitions only
`ifndef PRC_DEFINES_SVH
`define PRC_DEFINES_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define PRC_ADDR_REF_PWR 8'h1C
`define PRC_ADDR_REF_OPT 8'h1D
`define PRC_ADDR_PLL_STAT 8'h1F

// ----------------------------------------
// Reference power and mode fields
// ----------------------------------------
`define PRC_BIT_SECOND_PWR 2
`define PRC_BIT_FIRST_PWR 1
`define PRC_BIT_DIFF_MODE 0
`define PRC_MASK_REF_PWR 8'h07

// ----------------------------------------
// Options and status route fields
// ----------------------------------------
`define PRC_BIT_EEPROM_ROUTE 7
`define PRC_BIT_CRYSTAL_AMP 6
`define PRC_BIT_DOUBLER 5
`define PRC_BIT_STAT_FREEZE 4
`define PRC_MASK_REF_OPT 8'hF0

// ----------------------------------------
// Reset values
// ----------------------------------------
`define PRC_RST_REF_PWR 8'h00
`define PRC_RST_REF_OPT 8'h80
`define PRC_RST_ZERO 8'h00

`endif

// ===== core/prc_pkg.sv
// Purpose: Types shared by the reference input config bank
// Assumes: Constants live in prc_defines.svh
// Notes: Types only
package prc_pkg;

	// Register port request
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} prc_req_t;

	// State of the config bank apart from the held PLL status
	typedef struct packed {
		logic [7:0] ref_pwr;
		logic [7:0] ref_opt;
		logic [7:0] rd_data;
		logic rd_valid;
		logic status_pin;
	} prc_cfg_state_t;

	// State of the status readback holder
	typedef struct packed {
		logic [7:0] held;
	} prc_hold_state_t;

endpackage

// ===== core/prc_status_hold.sv
// Purpose: PLL status readback register that can be frozen
// Assumes: Live status is synchronous to clk_in
// Notes: Output comes from a flop
`timescale 1ns/10ps
`include "prc_defines.svh"

module prc_status_hold #(
	parameter int WIDTH = 8
) (
	input wire logic clk_in, // System clock
	input wire logic rst_b_in, // Async reset, active low
	input wire logic freeze_in, // Hold contents when high
	input wire logic [WIDTH-1:0] live_in, // Live PLL status
	output logic [WIDTH-1:0] held_out // Readback contents
);

	logic [WIDTH-1:0] held_ff;
	logic [WIDTH-1:0] nxt_held;

	// ----------------------------------------
	// Refresh unless frozen
	// ----------------------------------------
	always_comb begin
		nxt_held = held_ff;
		if (!freeze_in) begin
			nxt_held = live_in;
		end
	end

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			held_ff <= '0;
		end else begin
			held_ff <= nxt_held;
		end
	end

	assign held_out = held_ff;

endmodule

// ===== core/prc_ref_cfg.sv
// Purpose: Reference input power, mode and option bits of a clock generator PLL
// Assumes: Serial control port decoded upstream into byte write and read strobes
// Notes: Analog paths, status selector field and EEPROM sit outside
// How it works
// - Bit 2 powers second reference input on; off after reset.
// - Bit 1 powers first reference input on; off after reset.
// - Bit 0 chooses mode: zero single-ended, one differential.
// - Bit 7 routes EEPROM status to status pin over selector; default one.
// - Bit 6 enables crystal maintaining amplifier; disabled after reset.
// - Bit 5 enables reference doubler; bypassed after reset.
// - Bit 4 freezes PLL status readback; updates continue by default.
// - Reset leaves the block in single-ended reference mode.
`timescale 1ns/10ps
`include "prc_defines.svh"

module prc_ref_cfg #(
	parameter int STAT_W = 8
) (
	input wire logic clk_in, // System clock, 100 MHz
	input wire logic rst_b_in, // Async reset, active low
	input wire logic reg_wr_in, // Register write strobe
	input wire logic reg_rd_in, // Register read strobe
	input wire logic [7:0] reg_addr_in, // Register byte address
	input wire logic [7:0] reg_wdata_in, // Write data
	input wire logic eeprom_status_in, // EEPROM status signal
	input wire logic sel_status_in, // Output of the status selector field
	input wire logic [STAT_W-1:0] pll_live_status_in, // Live PLL status bits
	output logic [7:0] reg_rdata_out, // Read data
	output logic reg_rvalid_out, // Read data valid pulse
	output logic second_reference_input_pwr_out, // Second input powered
	output logic first_reference_input_pwr_out, // First input powered
	output logic diff_mode_out, // Differential reference mode
	output logic crystal_maintaining_amplifier_en_out, // Crystal amplifier on
	output logic doubler_en_out, // Reference doubler on
	output logic status_pin_out, // Status pin level
	output logic [STAT_W-1:0] pll_status_out // Status readback contents
);

	prc_pkg::prc_cfg_state_t state_ff;
	prc_pkg::prc_cfg_state_t nxt_state;
	prc_pkg::prc_req_t req;
	logic [STAT_W-1:0] held_stat;

	// Bundle the port request
	assign req = '{wr: reg_wr_in, rd: reg_rd_in, addr: reg_addr_in, wdata: reg_wdata_in};

	// ----------------------------------------
	// Readback decode
	// ----------------------------------------
	// Unmapped addresses read zero rather than stale data
	function automatic logic [7:0] read_mux(input logic [7:0] addr, input prc_pkg::prc_cfg_state_t s,
			input logic [7:0] stat);
		logic [7:0] r;
		r = `PRC_RST_ZERO;
		if (addr == `PRC_ADDR_REF_PWR) begin
			r = s.ref_pwr;
		end else if (addr == `PRC_ADDR_REF_OPT) begin
			r = s.ref_opt;
		end else if (addr == `PRC_ADDR_PLL_STAT) begin
			r = stat;
		end
		return r;
	endfunction

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		nxt_state = state_ff;
		nxt_state.rd_valid = 1'b0;
		if (req.wr && req.addr == `PRC_ADDR_REF_PWR) begin
			nxt_state.ref_pwr = req.wdata & `PRC_MASK_REF_PWR;
		end
		if (req.wr && req.addr == `PRC_ADDR_REF_OPT) begin
			nxt_state.ref_opt = req.wdata & `PRC_MASK_REF_OPT;
		end
		if (req.rd) begin
			// Cast fits the status word to a byte whatever STAT_W is
			nxt_state.rd_data = read_mux(req.addr, state_ff, 8'(held_stat));
			nxt_state.rd_valid = 1'b1;
		end
		if (state_ff.ref_opt[`PRC_BIT_EEPROM_ROUTE]) begin
			nxt_state.status_pin = eeprom_status_in;
		end else begin
			nxt_state.status_pin = sel_status_in;
		end
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			state_ff <= '{ref_pwr: `PRC_RST_REF_PWR, ref_opt: `PRC_RST_REF_OPT, rd_data: `PRC_RST_ZERO,
				rd_valid: 1'b0, status_pin: 1'b0};
		end else begin
			state_ff <= nxt_state;
		end
	end

	prc_status_hold #(
		.WIDTH(STAT_W)
	) u_hold (
		.clk_in(clk_in),
		.rst_b_in(rst_b_in),
		.freeze_in(state_ff.ref_opt[`PRC_BIT_STAT_FREEZE]),
		.live_in(pll_live_status_in),
		.held_out(held_stat)
	);

	// ----------------------------------------
	// Outputs, all from flops
	// ----------------------------------------
	// Diff mode with power bits set is software's fault; passed through as written
	assign second_reference_input_pwr_out = state_ff.ref_pwr[`PRC_BIT_SECOND_PWR];
	assign first_reference_input_pwr_out = state_ff.ref_pwr[`PRC_BIT_FIRST_PWR];
	assign diff_mode_out = state_ff.ref_pwr[`PRC_BIT_DIFF_MODE];
	assign crystal_maintaining_amplifier_en_out = state_ff.ref_opt[`PRC_BIT_CRYSTAL_AMP];
	assign doubler_en_out = state_ff.ref_opt[`PRC_BIT_DOUBLER];
	assign status_pin_out = state_ff.status_pin;
	assign reg_rdata_out = state_ff.rd_data;
	assign reg_rvalid_out = state_ff.rd_valid;
	assign pll_status_out = held_stat;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_b_in);

	property p_second_pwr;
		reg_wr_in && reg_addr_in == `PRC_ADDR_REF_PWR |=>
			second_reference_input_pwr_out == $past(reg_wdata_in[`PRC_BIT_SECOND_PWR]);
	endproperty
	a_second_pwr: assert property (p_second_pwr) else $error("second input power bit wrong");

	property p_first_pwr;
		reg_wr_in && reg_addr_in == `PRC_ADDR_REF_PWR |=>
			first_reference_input_pwr_out == $past(reg_wdata_in[`PRC_BIT_FIRST_PWR]);
	endproperty
	a_first_pwr: assert property (p_first_pwr) else $error("first input power bit wrong");

	property p_diff_write;
		reg_wr_in && reg_addr_in == `PRC_ADDR_REF_PWR |=>
			diff_mode_out == $past(reg_wdata_in[`PRC_BIT_DIFF_MODE]);
	endproperty
	a_diff_write: assert property (p_diff_write) else $error("mode bit not taken from write");

	property p_mode;
		!(reg_wr_in && reg_addr_in == `PRC_ADDR_REF_PWR) |=> $stable(diff_mode_out);
	endproperty
	a_mode: assert property (p_mode) else $error("mode changed without write");

	property p_route;
		##1 status_pin_out == ($past(state_ff.ref_opt[`PRC_BIT_EEPROM_ROUTE]) ?
			$past(eeprom_status_in) : $past(sel_status_in));
	endproperty
	a_route: assert property (p_route) else $error("status pin route wrong");

	property p_crystal;
		reg_wr_in && reg_addr_in == `PRC_ADDR_REF_OPT ##1 !reg_wr_in |=>
			crystal_maintaining_amplifier_en_out == $past(reg_wdata_in[`PRC_BIT_CRYSTAL_AMP], 2);
	endproperty
	a_crystal: assert property (p_crystal) else $error("crystal amplifier bit wrong");

	property p_doubler;
		reg_wr_in && reg_addr_in == `PRC_ADDR_REF_OPT |=>
			doubler_en_out == $past(reg_wdata_in[`PRC_BIT_DOUBLER]);
	endproperty
	a_doubler: assert property (p_doubler) else $error("doubler bit wrong");

	// Option outputs only move on a write to their register
	property p_opt_hold;
		!(reg_wr_in && reg_addr_in == `PRC_ADDR_REF_OPT) |=>
			$stable(crystal_maintaining_amplifier_en_out) && $stable(doubler_en_out);
	endproperty
	a_opt_hold: assert property (p_opt_hold) else $error("option bits changed without write");

	property p_freeze;
		state_ff.ref_opt[`PRC_BIT_STAT_FREEZE] && $past(state_ff.ref_opt[`PRC_BIT_STAT_FREEZE]) |->
			$stable(pll_status_out);
	endproperty
	a_freeze: assert property (p_freeze) else $error("status changed while frozen");

	property p_track;
		!state_ff.ref_opt[`PRC_BIT_STAT_FREEZE] |=> pll_status_out == $past(pll_live_status_in);
	endproperty
	a_track: assert property (p_track) else $error("status not refreshed");

	property p_stat_read;
		reg_rd_in && reg_addr_in == `PRC_ADDR_PLL_STAT |=>
			reg_rvalid_out && reg_rdata_out == 8'($past(pll_status_out));
	endproperty
	a_stat_read: assert property (p_stat_read) else $error("status readback wrong");

	property p_reset_mode;
		$rose(rst_b_in) |-> !diff_mode_out && status_pin_out == 1'b0;
	endproperty
	a_reset_mode: assert property (@(posedge clk_in) disable iff (1'b0) p_reset_mode)
		else $error("not single-ended after reset");

	property p_readback;
		reg_rd_in && reg_addr_in == `PRC_ADDR_REF_PWR && !reg_wr_in |=>
			reg_rvalid_out && reg_rdata_out == $past(state_ff.ref_pwr) &&
			(reg_rdata_out & ~`PRC_MASK_REF_PWR) == `PRC_RST_ZERO;
	endproperty
	a_readback: assert property (p_readback) else $error("readback wrong");

	property p_opt_readback;
		reg_rd_in && reg_addr_in == `PRC_ADDR_REF_OPT |=>
			reg_rvalid_out && reg_rdata_out == $past(state_ff.ref_opt) &&
			(reg_rdata_out & ~`PRC_MASK_REF_OPT) == `PRC_RST_ZERO;
	endproperty
	a_opt_readback: assert property (p_opt_readback) else $error("option readback wrong");

	// Holes in the map answer zero so software never sees stale data
	property p_unmapped_read;
		reg_rd_in && reg_addr_in != `PRC_ADDR_REF_PWR && reg_addr_in != `PRC_ADDR_REF_OPT &&
			reg_addr_in != `PRC_ADDR_PLL_STAT |=> reg_rvalid_out && reg_rdata_out == `PRC_RST_ZERO;
	endproperty
	a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not zero");

	property p_rvalid_pulse;
		!reg_rd_in |=> !reg_rvalid_out;
	endproperty
	a_rvalid_pulse: assert property (p_rvalid_pulse) else $error("read valid without read");

	c_diff_mode: cover property (reg_wr_in && reg_addr_in == `PRC_ADDR_REF_PWR && reg_wdata_in == 8'h01);
	c_eeprom_off: cover property ($fell(state_ff.ref_opt[`PRC_BIT_EEPROM_ROUTE]));
	c_freeze: cover property ($rose(state_ff.ref_opt[`PRC_BIT_STAT_FREEZE]) ##[1:32]
		$fell(state_ff.ref_opt[`PRC_BIT_STAT_FREEZE]));
	c_read_stat: cover property (reg_rvalid_out && $past(reg_addr_in) == `PRC_ADDR_PLL_STAT);

endmodule

// ===== bench/tb_prc_ref_cfg.sv
// Purpose: Self-checking bench for the reference input config bank
// Assumes: One 100 MHz clock, single-byte register strobes
// Notes: Inputs change by non-blocking assignment on the rising edge
`timescale 1ns/10ps
`include "prc_defines.svh"

module tb_prc_ref_cfg;
	logic clk_in;
	logic rst_b_in;
	logic reg_wr_in;
	logic reg_rd_in;
	logic [7:0] reg_addr_in;
	logic [7:0] reg_wdata_in;
	logic eeprom_status_in;
	logic sel_status_in;
	logic [7:0] pll_live_status_in;
	logic [7:0] reg_rdata_out;
	logic reg_rvalid_out;
	logic second_pwr;
	logic first_pwr;
	logic diff_mode;
	logic xtal_en;
	logic dbl_en;
	logic status_pin;
	logic [7:0] pll_status;
	int errors = 0;
	int n_tests = 0;

	prc_ref_cfg #(.STAT_W(8)) dut (.clk_in(clk_in), .rst_b_in(rst_b_in), .reg_wr_in(reg_wr_in),
		.reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
		.eeprom_status_in(eeprom_status_in), .sel_status_in(sel_status_in),
		.pll_live_status_in(pll_live_status_in), .reg_rdata_out(reg_rdata_out),
		.reg_rvalid_out(reg_rvalid_out), .second_reference_input_pwr_out(second_pwr),
		.first_reference_input_pwr_out(first_pwr), .diff_mode_out(diff_mode),
		.crystal_maintaining_amplifier_en_out(xtal_en), .doubler_en_out(dbl_en),
		.status_pin_out(status_pin), .pll_status_out(pll_status));

	// ----------------------------------------
	// Clock and shared tasks
	// ----------------------------------------
	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end

	// Compare one value, bits widened to a byte
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask

	// One-cycle write strobe
	task automatic wr(input logic [7:0] addr, input logic [7:0] data);
		@(posedge clk_in);
		reg_wr_in <= 1'b1;
		reg_addr_in <= addr;
		reg_wdata_in <= data;
		@(posedge clk_in);
		reg_wr_in <= 1'b0;
	endtask

	// One-cycle read strobe, data looked at while valid stands
	task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
		@(posedge clk_in);
		reg_rd_in <= 1'b1;
		reg_addr_in <= addr;
		@(posedge clk_in);
		reg_rd_in <= 1'b0;
		#1;
		chk("rvalid", 8'h01, {7'h00, reg_rvalid_out});
		chk("rdata", exp, reg_rdata_out);
	endtask

	// Let two edges land so a fresh bit reaches the pin
	task automatic settle();
		repeat (2) @(posedge clk_in);
		#1;
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset();
		#1;
		chk("pwr_mode", 8'h00, {5'h00, second_pwr, first_pwr, diff_mode});
		chk("opts", 8'h00, {6'h00, xtal_en, dbl_en});
		rd_chk(`PRC_ADDR_REF_PWR, 8'h00);
		rd_chk(`PRC_ADDR_REF_OPT, 8'h80);
		$display("test reset done");
	endtask

	task automatic t_power_mode();
		wr(`PRC_ADDR_REF_PWR, 8'hFE);
		settle();
		chk("pwr_both", 8'h06, {5'h00, second_pwr, first_pwr, diff_mode});
		rd_chk(`PRC_ADDR_REF_PWR, 8'h06);
		// Differential mode with both single-ended supplies cleared
		wr(`PRC_ADDR_REF_PWR, 8'h01);
		wr(`PRC_ADDR_REF_PWR, 8'h04);
		settle();
		chk("pwr_second", 8'h04, {5'h00, second_pwr, first_pwr, diff_mode});
		wr(`PRC_ADDR_REF_PWR, 8'h01);
		settle();
		chk("diff", 8'h01, {5'h00, second_pwr, first_pwr, diff_mode});
		$display("test power_mode done");
	endtask

	task automatic t_options();
		@(posedge clk_in);
		eeprom_status_in <= 1'b1;
		sel_status_in <= 1'b0;
		settle();
		chk("pin_eeprom", 8'h01, {7'h00, status_pin});
		wr(`PRC_ADDR_REF_OPT, 8'h6F);
		settle();
		chk("pin_sel", 8'h00, {7'h00, status_pin});
		chk("opts_on", 8'h03, {6'h00, xtal_en, dbl_en});
		rd_chk(`PRC_ADDR_REF_OPT, 8'h60);
		@(posedge clk_in);
		sel_status_in <= 1'b1;
		eeprom_status_in <= 1'b0;
		settle();
		chk("pin_sel_hi", 8'h01, {7'h00, status_pin});
		wr(`PRC_ADDR_REF_OPT, 8'h40);
		settle();
		chk("xtal_only", 8'h02, {6'h00, xtal_en, dbl_en});
		$display("test options done");
	endtask

	task automatic t_freeze();
		@(posedge clk_in);
		pll_live_status_in <= 8'hA5;
		settle();
		chk("live", 8'hA5, pll_status);
		wr(`PRC_ADDR_REF_OPT, 8'h10);
		pll_live_status_in <= 8'h3C;
		settle();
		chk("held", 8'hA5, pll_status);
		rd_chk(`PRC_ADDR_PLL_STAT, 8'hA5);
		// Status readback is read-only, a write must leave it alone
		wr(`PRC_ADDR_PLL_STAT, 8'hFF);
		rd_chk(`PRC_ADDR_PLL_STAT, 8'hA5);
		rd_chk(8'h3A, 8'h00);
		wr(`PRC_ADDR_REF_OPT, 8'h00);
		settle();
		chk("resumed", 8'h3C, pll_status);
		$display("test freeze done");
	endtask

	// ----------------------------------------
	// Verdict, watchdog and main sequence
	// ----------------------------------------
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// Tests need under a hundred cycles; allow far more
	initial begin
		repeat (3000) @(posedge clk_in);
		errors++;
		give_verdict();
	end

	initial begin
		rst_b_in = 1'b0;
		reg_wr_in = 1'b0;
		reg_rd_in = 1'b0;
		reg_addr_in = 8'h00;
		reg_wdata_in = 8'h00;
		eeprom_status_in = 1'b0;
		sel_status_in = 1'b0;
		pll_live_status_in = 8'h00;
		repeat (16) @(posedge clk_in);
		rst_b_in <= 1'b1;
		t_reset();
		t_power_mode();
		t_options();
		t_freeze();
		give_verdict();
	end
endmodule
